// ---- inc/flash_bus_pkg.sv ----
package flash_bus_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_ID} rd_mode_e;
    typedef enum logic [1:0] {PEND_NONE, PEND_PROG, PEND_ERASE, PEND_CFG}
        pend_e;
endpackage

// ---- inc/flash_bus_regs.svh ----
`ifndef FLASH_BUS_REGS_SVH
`define FLASH_BUS_REGS_SVH

// read configuration register fields
`define FB_RCR_RESET 16'h8000
`define FB_RCR_MODE_BIT 15
`define FB_RCR_LAT_MSB 14
`define FB_RCR_LAT_LSB 11
`define FB_RCR_WAIT_POL_BIT 10

// status register
`define FB_SR_RESET 8'h80
`define FB_SR_READY_BIT 7
`define FB_SR_ERASE_ERR_BIT 5
`define FB_SR_PROG_ERR_BIT 4
`define FB_SR_LOCK_ERR_BIT 1

// word offset bits inside one main block
`define FB_BLK_OFS_BITS 16

// command codes
`define FB_CMD_READ_ARRAY 8'hFF
`define FB_CMD_READ_STATUS 8'h70
`define FB_CMD_READ_ID 8'h90
`define FB_CMD_CLEAR_SR 8'h50
`define FB_CMD_PROG_SETUP 8'h40
`define FB_CMD_ERASE_SETUP 8'h20
`define FB_CMD_CFG_SETUP 8'h60
`define FB_CMD_CONFIRM 8'hD0
`define FB_CMD_SET_RCR 8'h03
`define FB_CMD_LOCK 8'h01
`define FB_CMD_LOCK_DOWN 8'h2F

// automation run times in clk cycles
`define FB_PROG_CYCLES 64
`define FB_ERASE_CYCLES 256

`endif

// ---- inc/flash_core_if.sv ----
`timescale 1ns/1ps
interface flash_core_if #(parameter int ADDR_MSB = 25);
    logic wr_stb;
    logic [ADDR_MSB:1] wr_addr;
    flash_bus_pkg::word_t wr_data;
    logic [ADDR_MSB:1] rd_addr;
    flash_bus_pkg::word_t rd_data;
    flash_bus_pkg::word_t read_config_reg;
    logic hold_rst;
    logic wp_n;

    modport bus (output wr_stb, wr_addr, wr_data, rd_addr, hold_rst, wp_n,
        input rd_data, read_config_reg);
    modport core (input wr_stb, wr_addr, wr_data, rd_addr, hold_rst, wp_n,
        output rd_data, read_config_reg);
endinterface

// ---- src/flash_core.sv ----
`timescale 1ns/1ps
`include "flash_bus_regs.svh"
module flash_core #(
    parameter int ADDR_MSB = 25,
    parameter int MEM_AW = 4,
    parameter int PROG_CYCLES = `FB_PROG_CYCLES,
    parameter int ERASE_CYCLES = `FB_ERASE_CYCLES
)(
    input wire logic clk,
    input wire logic arst_n,
    flash_core_if.core cif
);
    import flash_bus_pkg::*;

    localparam int NBLK = 2 ** (ADDR_MSB - `FB_BLK_OFS_BITS);
    localparam int MW = 2 ** MEM_AW;
    localparam int CW = $clog2(ERASE_CYCLES + 1);

    generate
        if (MEM_AW < 1 || MEM_AW > `FB_BLK_OFS_BITS || PROG_CYCLES < 1 ||
            ERASE_CYCLES < PROG_CYCLES)
        begin : g_bad
            $error("flash_core: unusable parameters");
        end
    endgenerate

    word_t rcr_r, rcr_nxt;
    logic [7:0] sr_r, sr_nxt;
    rd_mode_e mode_r, mode_nxt;
    pend_e pend_r, pend_nxt;
    logic [CW-1:0] busy_r, busy_nxt;
    logic erase_r, erase_nxt;
    logic [MEM_AW-1:0] op_addr_r, op_addr_nxt;
    word_t op_data_r, op_data_nxt;
    logic [NBLK-1:0] lock_r, lock_nxt, ldn_r, ldn_nxt;
    word_t mem_r [MW];
    word_t mem_nxt [MW];
    logic [ADDR_MSB-`FB_BLK_OFS_BITS-1:0] blk;
    logic [7:0] cmd;

    // upper address bits name the block, a25 picks the die
    assign blk = cif.wr_addr[ADDR_MSB:`FB_BLK_OFS_BITS+1]; // [RL3] [RL5]
    assign cmd = cif.wr_data[7:0];
    assign cif.read_config_reg = rcr_r;

    always_comb
    begin
        unique case (mode_r)
            MODE_STATUS: cif.rd_data = {8'h00, sr_r};
            MODE_ID: cif.rd_data = rcr_r;
            default: cif.rd_data = mem_r[cif.rd_addr[MEM_AW:1]]; // [RL24]
        endcase
    end

    always_comb
    begin
        rcr_nxt = rcr_r;
        sr_nxt = sr_r;
        mode_nxt = mode_r;
        pend_nxt = pend_r;
        busy_nxt = busy_r;
        erase_nxt = erase_r;
        op_addr_nxt = op_addr_r;
        op_data_nxt = op_data_r;
        lock_nxt = lock_r;
        ldn_nxt = ldn_r;
        mem_nxt = mem_r;
        // automation runs to the end whatever the chip select does
        if (busy_r != '0)
        begin
            busy_nxt = busy_r - CW'(1); // [RL12]
            if (busy_r == CW'(1))
            begin
                if (erase_r)
                begin
                    for (int i = 0; i < MW; i++)
                        mem_nxt[i] = 16'hFFFF;
                end
                else
                    mem_nxt[op_addr_r] = mem_r[op_addr_r] & op_data_r;
            end
        end
        if (cif.wr_stb && busy_r != '0)
        begin
            if (cmd == `FB_CMD_READ_STATUS)
                mode_nxt = MODE_STATUS;
        end
        else if (cif.wr_stb)
        begin
            unique case (pend_r)
                PEND_PROG:
                begin
                    mode_nxt = MODE_STATUS;
                    if (lock_r[blk])
                    begin
                        sr_nxt[`FB_SR_PROG_ERR_BIT] = 1'b1;
                        sr_nxt[`FB_SR_LOCK_ERR_BIT] = 1'b1;
                    end
                    else
                    begin
                        busy_nxt = CW'(PROG_CYCLES);
                        erase_nxt = 1'b0;
                        op_addr_nxt = cif.wr_addr[MEM_AW:1];
                        op_data_nxt = cif.wr_data;
                    end
                end
                PEND_ERASE:
                begin
                    mode_nxt = MODE_STATUS;
                    if (cmd != `FB_CMD_CONFIRM)
                    begin
                        sr_nxt[`FB_SR_ERASE_ERR_BIT] = 1'b1;
                        sr_nxt[`FB_SR_PROG_ERR_BIT] = 1'b1;
                    end
                    else if (lock_r[blk])
                    begin
                        sr_nxt[`FB_SR_ERASE_ERR_BIT] = 1'b1;
                        sr_nxt[`FB_SR_LOCK_ERR_BIT] = 1'b1;
                    end
                    else
                    begin
                        busy_nxt = CW'(ERASE_CYCLES);
                        erase_nxt = 1'b1;
                    end
                end
                PEND_CFG:
                begin
                    if (cmd == `FB_CMD_SET_RCR)
                    begin
                        rcr_nxt = cif.wr_addr[16:1]; // [RL23]
                        mode_nxt = MODE_ARRAY;
                    end
                    else if (cmd == `FB_CMD_LOCK)
                        lock_nxt[blk] = 1'b1;
                    else if (cmd == `FB_CMD_LOCK_DOWN)
                    begin
                        lock_nxt[blk] = 1'b1;
                        ldn_nxt[blk] = 1'b1;
                    end
                    else if (cmd == `FB_CMD_CONFIRM)
                    begin
                        // protect low keeps lock-down; high lets it go
                        if (!ldn_r[blk] || cif.wp_n) // [RL16] [RL17]
                            lock_nxt[blk] = 1'b0;
                    end
                    else
                    begin
                        sr_nxt[`FB_SR_ERASE_ERR_BIT] = 1'b1;
                        sr_nxt[`FB_SR_PROG_ERR_BIT] = 1'b1;
                        mode_nxt = MODE_STATUS;
                    end
                end
                default:
                begin
                    unique case (cmd)
                        `FB_CMD_READ_ARRAY: mode_nxt = MODE_ARRAY;
                        `FB_CMD_READ_STATUS: mode_nxt = MODE_STATUS;
                        `FB_CMD_READ_ID: mode_nxt = MODE_ID;
                        `FB_CMD_CLEAR_SR: sr_nxt = `FB_SR_RESET;
                        `FB_CMD_PROG_SETUP: pend_nxt = PEND_PROG;
                        `FB_CMD_ERASE_SETUP: pend_nxt = PEND_ERASE;
                        `FB_CMD_CFG_SETUP: pend_nxt = PEND_CFG;
                        default: pend_nxt = PEND_NONE;
                    endcase
                end
            endcase
            if (pend_r != PEND_NONE)
                pend_nxt = PEND_NONE;
        end
        sr_nxt[`FB_SR_READY_BIT] = (busy_nxt == '0);
        // pin reset aborts automation; a run in its last busy cycle still writes its data
        if (cif.hold_rst)
        begin
            rcr_nxt = `FB_RCR_RESET; // [RL19]
            sr_nxt = `FB_SR_RESET; // [RL19]
            mode_nxt = MODE_ARRAY;
            pend_nxt = PEND_NONE;
            busy_nxt = '0; // [RL18] [RL20]
            erase_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rcr_r <= `FB_RCR_RESET;
            sr_r <= `FB_SR_RESET;
            mode_r <= MODE_ARRAY;
            pend_r <= PEND_NONE;
            busy_r <= '0;
            erase_r <= 1'b0;
            op_addr_r <= '0;
            op_data_r <= 16'hFFFF;
            lock_r <= '0;
            ldn_r <= '0;
            for (int i = 0; i < MW; i++)
                mem_r[i] <= 16'hFFFF;
        end
        else
        begin
            rcr_r <= rcr_nxt;
            sr_r <= sr_nxt;
            mode_r <= mode_nxt;
            pend_r <= pend_nxt;
            busy_r <= busy_nxt;
            erase_r <= erase_nxt;
            op_addr_r <= op_addr_nxt;
            op_data_r <= op_data_nxt;
            lock_r <= lock_nxt;
            ldn_r <= ldn_nxt;
            mem_r <= mem_nxt;
        end
    end
endmodule

// ---- src/nor_flash_bus_interface.sv ----
`timescale 1ns/1ps
`include "flash_bus_regs.svh"
// Notes on behaviour
// [RL1] sync mode: capture at strobe rise or clock
// [RL2] async mode: capture on rise, flow while low
// [RL3] strobe low opens latches, upper bits pick block
// [RL4] 24 address bits, or 25 on big part
// [RL5] top address bit high picks top die
// [RL6] host reads with select and output enable
// [RL7] host writes with select and write enable
// [RL8] write latched at first rising strobe edge
// [RL9] data floats when select or enable off
// [RL10] output enable high floats data and wait
// [RL11] deselect is standby, all outputs floating
// [RL12] deselect never stops running program or erase
// [RL13] wait polarity from config bit ten
// [RL14] sync burst: wait asserted while data invalid
// [RL15] async and write modes keep wait deasserted
// [RL16] protect low keeps lock-down against unlock
// [RL17] protect high overrides lock-down
// [RL18] reset stops automation, writes, floats outputs
// [RL19] after reset: async array read, status 0x80
// [RL20] reset aborts program or erase midway
// [RL21] host waits after reset before access
// [RL22] host shares reset with its processor
// [RL23] sync burst only after config register set
// [RL24] lowest address pin is word bit zero
// [RL25] unused address strobe is tied low
module nor_flash_bus_interface #(
    parameter int ADDR_MSB = 25,
    parameter int MEM_AW = 4,
    parameter int PROG_CYCLES = `FB_PROG_CYCLES,
    parameter int ERASE_CYCLES = `FB_ERASE_CYCLES
)(
    // system
    input wire logic clk,
    input wire logic arst_n,
    // host control pins
    input wire logic bus_clk,
    input wire logic addr_valid_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic flash_rst_n,
    input wire logic wp_n,
    // address and data pins
    input wire logic [ADDR_MSB:1] addr,
    input wire flash_bus_pkg::word_t dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe,
    // wait indicator and die select
    output logic wait_out,
    output logic wait_oe,
    output logic top_die_sel
);
    import flash_bus_pkg::*;

    localparam int AW = ADDR_MSB;
    localparam int SW = 7 + AW + 16;

    generate
        if (ADDR_MSB != 24 && ADDR_MSB != 25) // [RL4]
        begin : g_bad
            $error("nor_flash_bus_interface: address must be 24 or 25 bits");
        end
    endgenerate

    flash_core_if #(.ADDR_MSB(ADDR_MSB)) cif ();

    // two-flop synchroniser on every pin
    logic [SW-1:0] s1_r, s2_r;
    logic clk_s, adv_s, ce_s, oe_s, we_s, rst_s, wp_s;
    logic [AW:1] addr_s;
    word_t dq_s;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r <= '1;
            s2_r <= '1;
        end
        else
        begin
            s1_r <= {bus_clk, addr_valid_n, ce_n, oe_n, we_n, flash_rst_n,
                wp_n, addr, dq_in};
            s2_r <= s1_r;
        end
    end

    assign {clk_s, adv_s, ce_s, oe_s, we_s, rst_s, wp_s, addr_s, dq_s} = s2_r;

    // address latch and sync burst tracking
    logic clk_d_r, clk_d_nxt, adv_d_r, adv_d_nxt;
    logic [AW:1] lat_addr_r, lat_addr_nxt;
    logic cap_r, cap_nxt, bval_r, bval_nxt;
    logic [3:0] lat_cnt_r, lat_cnt_nxt;
    logic run, sync_mode, clk_rise, adv_rise, adv_fall;

    assign run = rst_s;
    // config reset value leaves sync mode off until software sets it
    assign sync_mode = ~cif.read_config_reg[`FB_RCR_MODE_BIT]; // [RL23]
    assign clk_rise = clk_s & ~clk_d_r;
    assign adv_rise = adv_s & ~adv_d_r;
    assign adv_fall = ~adv_s & adv_d_r;

    always_comb
    begin
        clk_d_nxt = clk_s;
        adv_d_nxt = adv_s;
        lat_addr_nxt = lat_addr_r;
        cap_nxt = cap_r;
        bval_nxt = bval_r;
        lat_cnt_nxt = lat_cnt_r;
        if (!run || ce_s)
        begin
            cap_nxt = 1'b0;
            bval_nxt = 1'b0;
        end
        else if (!sync_mode)
        begin
            if (!adv_s)
                lat_addr_nxt = addr_s; // [RL2] [RL3] [RL25]
            cap_nxt = 1'b0;
            bval_nxt = 1'b0;
        end
        else if (adv_fall)
        begin
            cap_nxt = 1'b0; // [RL3]
            bval_nxt = 1'b0;
        end
        else if (!cap_r && !adv_d_r && (adv_rise || clk_rise))
        begin
            lat_addr_nxt = addr_s; // [RL1]
            cap_nxt = 1'b1;
            lat_cnt_nxt = cif.read_config_reg[`FB_RCR_LAT_MSB:`FB_RCR_LAT_LSB];
        end
        else if (!cap_r && !adv_s) // latch open until something captures
            lat_addr_nxt = addr_s; // [RL3]
        else if (cap_r && clk_rise)
        begin
            if (lat_cnt_r != 4'h0)
                lat_cnt_nxt = lat_cnt_r - 4'h1;
            else
            begin
                if (bval_r)
                    lat_addr_nxt = lat_addr_r + AW'(1);
                bval_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_d_r <= 1'b1; // same as synchroniser reset: no false rise
            adv_d_r <= 1'b1;
            lat_addr_r <= '0;
            cap_r <= 1'b0;
            bval_r <= 1'b0;
            lat_cnt_r <= 4'h0;
        end
        else
        begin
            clk_d_r <= clk_d_nxt;
            adv_d_r <= adv_d_nxt;
            lat_addr_r <= lat_addr_nxt;
            cap_r <= cap_nxt;
            bval_r <= bval_nxt;
            lat_cnt_r <= lat_cnt_nxt;
        end
    end

    // write cycle: address and data held from the last active cycle
    logic wr_act, wr_act_r, wr_stb_r, wr_stb_nxt;
    logic [AW:1] wa_r, wa_nxt;
    word_t wd_r, wd_nxt;

    assign wr_act = run & ~ce_s & ~we_s & oe_s; // [RL18]

    always_comb
    begin
        wa_nxt = wa_r;
        wd_nxt = wd_r;
        if (wr_act)
        begin
            wa_nxt = sync_mode ? lat_addr_r : addr_s;
            wd_nxt = dq_s;
        end
        // first of the two strobes to rise ends the active window
        wr_stb_nxt = wr_act_r & ~wr_act & run; // [RL8]
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_act_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wa_r <= '0;
            wd_r <= '0;
        end
        else
        begin
            wr_act_r <= wr_act;
            wr_stb_r <= wr_stb_nxt;
            wa_r <= wa_nxt;
            wd_r <= wd_nxt;
        end
    end

    assign cif.wr_stb = wr_stb_r;
    assign cif.wr_addr = wa_r;
    assign cif.wr_data = wd_r;
    assign cif.rd_addr = lat_addr_r;
    assign cif.hold_rst = ~run; // [RL18] [RL20]
    assign cif.wp_n = wp_s;

    flash_core #(
        .ADDR_MSB(ADDR_MSB),
        .MEM_AW(MEM_AW),
        .PROG_CYCLES(PROG_CYCLES),
        .ERASE_CYCLES(ERASE_CYCLES)
    ) u_core (
        .clk(clk),
        .arst_n(arst_n),
        .cif(cif)
    );

    // output pins, all from flops
    logic [15:0] dq_nxt;
    logic dq_oe_nxt, wait_nxt, wait_oe_nxt, die_nxt, wait_act;

    always_comb
    begin
        dq_nxt = cif.rd_data;
        // deselect, output disable or reset float everything
        dq_oe_nxt = run & ~ce_s & ~oe_s & we_s; // [RL9] [RL11] [RL18]
        wait_oe_nxt = run & ~ce_s & ~oe_s; // [RL10] [RL11]
        // only a sync burst read ever asserts wait
        wait_act = sync_mode & we_s & ~bval_r; // [RL14] [RL15]
        wait_nxt = wait_act ? cif.read_config_reg[`FB_RCR_WAIT_POL_BIT]
            : ~cif.read_config_reg[`FB_RCR_WAIT_POL_BIT]; // [RL13]
        die_nxt = (AW == 25) & lat_addr_r[AW]; // [RL5]
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dq_out <= '0;
            dq_oe <= 1'b0;
            wait_out <= 1'b0;
            wait_oe <= 1'b0;
            top_die_sel <= 1'b0;
        end
        else
        begin
            dq_out <= dq_nxt;
            dq_oe <= dq_oe_nxt;
            wait_out <= wait_nxt;
            wait_oe <= wait_oe_nxt;
            top_die_sel <= die_nxt;
        end
    end
endmodule

// ---- verification/flash_host_model.sv ----
`timescale 1ns/1ps
module flash_host_model (
    // system
    input wire logic clk,
    input wire logic sys_rst_n,
    // pins toward the flash
    output logic bus_clk,
    output logic addr_valid_n,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic flash_rst_n,
    output logic wp_n,
    output logic [25:1] addr,
    output flash_bus_pkg::word_t dq_in,
    // flash outputs
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    input wire logic wait_out,
    input wire logic wait_oe
);
    import flash_bus_pkg::*;
    logic own_rst_n;
    word_t bq[$];
    logic bw[$];
    // flash reset follows the system reset, so boot reads see the array
    assign flash_rst_n = sys_rst_n & own_rst_n;
    initial
    begin
        {bus_clk, own_rst_n} = 2'h1;
        {ce_n, oe_n, we_n, wp_n} = 4'hF;
        addr_valid_n = 1'b0;
        addr = '0;
        dq_in = 16'h0000;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // the pin left low stays selected: the first rise must latch
    task automatic wr(input logic [25:1] a, input word_t d, input bit cf);
        addr = a;
        dq_in = d;
        {ce_n, we_n} = 2'h0;
        step(4);
        if (cf)
            ce_n = 1'b1;
        else
            we_n = 1'b1;
        step(1);
        addr = ~a;
        dq_in = ~d;
        step(2);
        {ce_n, we_n} = 2'h3;
        step(6);
    endtask
    task automatic protect(input logic v);
        wp_n = v;
    endtask
    task automatic rd(input logic [25:1] a, output word_t d,
        output logic drv, output logic wt);
        addr = a;
        {ce_n, oe_n} = 2'h0;
        step(6);
        d = dq_out;
        drv = dq_oe & wait_oe;
        wt = wait_out;
        {ce_n, oe_n} = 2'h3;
        step(4);
    endtask
    task automatic freset(input int n);
        own_rst_n = 1'b0;
        step(n);
        own_rst_n = 1'b1;
        step(10);
    endtask
    // link clock only runs inside a burst, phase free of clk
    task automatic burst(input logic [25:1] a, input bit adv_first);
        bq = {};
        bw = {};
        addr = a;
        {ce_n, oe_n} = 2'h0;
        step(4);
        if (adv_first)
        begin
            addr_valid_n = 1'b1;
            step(4);
            addr = ~a;
        end
        repeat (8)
        begin
            #62.5 bus_clk = 1'b1;
            #50 bq.push_back(dq_out);
            bw.push_back(wait_out);
            addr_valid_n = 1'b1;
            #12.5 bus_clk = 1'b0;
        end
        step(1);
        addr = a;
        {ce_n, oe_n, addr_valid_n} = 3'h6;
        step(6);
    endtask
endmodule

// ---- verification/nor_flash_bus_interface_sva.sv ----
`timescale 1ns/1ps
module nor_flash_bus_interface_sva #(
    parameter int ADDR_MSB = 25
)(
    // system
    input wire logic clk,
    input wire logic arst_n,
    // host pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic flash_rst_n,
    input wire logic addr_valid_n,
    input wire logic [ADDR_MSB:1] addr,
    // device drivers
    input wire logic dq_oe,
    input wire logic wait_oe,
    input wire logic top_die_sel
);
    // each control pin crosses two sync flops and one output flop: 3 clk
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    data_select_a: assert property (
        dq_oe |-> !$past(ce_n, 3) && !$past(oe_n, 3))
        else $error("data driven without select and enable");
    output_off_a: assert property (
        $past(oe_n, 3) |-> !dq_oe && !wait_oe)
        else $error("outputs driven while output enable high");
    standby_float_a: assert property (
        $past(ce_n, 3) |-> !dq_oe && !wait_oe)
        else $error("outputs driven while deselected");
    reset_float_a: assert property (
        !$past(flash_rst_n, 3) && !$past(flash_rst_n, 4) |->
        !dq_oe && !wait_oe)
        else $error("outputs driven during flash reset");
    wait_drive_a: assert property (
        wait_oe |-> !$past(oe_n, 3) && !$past(ce_n, 3) &&
        $past(flash_rst_n, 3))
        else $error("wait driven outside a read");
    read_drive_a: assert property (
        (!ce_n && !oe_n && we_n && flash_rst_n)[*5] |->
        ##2 dq_oe && wait_oe)
        else $error("read cycle not driving the pins");
    rise_cause_a: assert property (
        $rose(dq_oe) |-> $past(ce_n, 4) || $past(oe_n, 4) ||
        !$past(we_n, 4) || !$past(flash_rst_n, 4))
        else $error("data driver turned on at the wrong time");
    die_flow_a: assert property (
        (ADDR_MSB == 25 && !addr_valid_n && !ce_n && flash_rst_n &&
        $stable(addr))[*5] |->
        ##2 top_die_sel == $past(addr[ADDR_MSB], 2))
        else $error("die select not following top address bit");
endmodule
bind nor_flash_bus_interface nor_flash_bus_interface_sva #(
    .ADDR_MSB(ADDR_MSB)
) chk (
    .clk, .arst_n, .ce_n, .oe_n, .we_n, .flash_rst_n, .addr_valid_n,
    .addr, .dq_oe, .wait_oe, .top_die_sel
);

// ---- verification/nor_flash_bus_interface_tb_top.sv ----
`timescale 1ns/1ps
module nor_flash_bus_interface_tb_top;
    import flash_bus_pkg::*;
    logic clk, arst_n, bus_clk, addr_valid_n, ce_n, oe_n, we_n;
    logic flash_rst_n, wp_n, dq_oe, wait_out, wait_oe, top_die_sel;
    logic [25:1] addr;
    word_t dq_in, dq_out;
    word_t mem [16];
    int err_count, check_count, seed;
    nor_flash_bus_interface dut (
        .clk, .arst_n, .bus_clk, .addr_valid_n, .ce_n, .oe_n, .we_n,
        .flash_rst_n, .wp_n, .addr, .dq_in, .dq_out, .dq_oe, .wait_out,
        .wait_oe, .top_die_sel
    );
    flash_host_model host (
        .clk, .sys_rst_n(arst_n), .bus_clk, .addr_valid_n, .ce_n, .oe_n,
        .we_n, .flash_rst_n, .wp_n, .addr, .dq_in, .dq_out, .dq_oe,
        .wait_out, .wait_oe
    );
    function automatic word_t stat(bit perr, bit lerr);
        return {8'h00, 1'b1, 2'h0, perr, 2'h0, lerr, 1'b0};
    endfunction
    function automatic word_t prog_exp(word_t old, word_t d);
        return old & d;
    endfunction
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string w, input word_t e, input word_t g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cmd(input logic [25:1] a, input word_t d);
        host.wr(a, d, 1'($random(seed)));
    endtask
    task automatic rdchk(input logic [25:1] a, input word_t e, string w);
        word_t q;
        logic drv, wt;
        host.rd(a, q, drv, wt);
        chk(w, e, q);
        chk("driven", 1, drv);
        chk("async wait", 1, wt);
    endtask
    // bounded poll: a stuck busy bit shows up in the next compare
    task automatic poll(output word_t q);
        logic drv, wt;
        cmd(0, 16'h0070);
        repeat (40)
        begin
            host.rd(0, q, drv, wt);
            if (q[7] === 1'b1)
                break;
        end
    endtask
    task automatic prog(input int a, input word_t d, output word_t q);
        cmd(25'(a), 16'h0040);
        cmd(25'(a), d);
        poll(q);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        #400000;
        err_count++;
        finish_test();
    end
    initial
    begin
        word_t d, q;
        logic [25:1] ra;
        int a, off;
        seed = 22;
        err_count = 0;
        check_count = 0;
        arst_n = 1'b0;
        repeat (10) @(posedge clk);
        #1 arst_n = 1'b1;
        host.step(10);
        cmd(0, 16'h0090);
        rdchk(0, 16'h8000, "config");
        cmd(0, 16'h0070);
        rdchk(0, stat(0, 0), "status");
        cmd(0, 16'h0020);
        cmd(0, 16'h00D0);
        poll(q);
        chk("erase", stat(0, 0), q);
        foreach (mem[i])
            mem[i] = 16'hFFFF;
        repeat (8)
        begin
            a = $random(seed) & 15;
            d = $random(seed);
            prog(a, d, q);
            chk("prog", stat(0, 0), q);
            mem[a] = prog_exp(mem[a], d);
        end
        cmd(0, 16'h00FF);
        for (a = 0; a < 16; a++)
        begin
            ra = {9'($random(seed)), 12'h000, 4'(a)};
            rdchk(ra, mem[a], "array");
            chk("die", ra[25], top_die_sel);
        end
        cmd(15, 16'h0040);
        cmd(15, 16'h1234);
        host.step(80);
        prog(15, 16'hFFFF, q);
        chk("deselected run", stat(0, 0), q);
        mem[15] = prog_exp(mem[15], 16'h1234);
        cmd(14, 16'h0040);
        cmd(14, 16'h0000);
        host.step(10);
        host.freset(6);
        rdchk(14, mem[14], "aborted word");
        cmd(0, 16'h0070);
        rdchk(0, stat(0, 0), "status");
        host.protect(1'b0);
        cmd(0, 16'h0060);
        cmd(0, 16'h002F);
        cmd(0, 16'h0060);
        cmd(0, 16'h00D0);
        prog(13, 16'h0000, q);
        chk("locked down", stat(1, 1), q);
        cmd(0, 16'h0050);
        cmd(0, 16'h00FF);
        rdchk(13, mem[13], "kept word");
        rdchk(15, mem[15], "deselected word");
        host.protect(1'b1);
        cmd(0, 16'h0060);
        cmd(0, 16'h00D0);
        prog(13, 16'h0000, q);
        chk("override", stat(0, 0), q);
        mem[13] = 16'h0000;
        cmd(0, 16'h00FF);
        rdchk(13, mem[13], "override word");
        cmd(0, 16'h0060);
        cmd(0, 16'h0001);
        prog(12, 16'h0000, q);
        chk("locked", stat(1, 1), q);
        cmd(0, 16'h0050);
        cmd(25'h1400, 16'h0060);
        cmd(25'h1400, 16'h0003);
        for (int b = 0; b < 2; b++)
        begin
            a = $random(seed) & 7;
            host.burst(25'(a), b[0]);
            off = b ? 2 : 3;
            for (int k = 1; k < 8; k++)
            begin
                chk("burst wait", k < off, host.bw[k]);
                if (k >= off)
                    chk("burst", mem[a + k - off], host.bq[k]);
            end
        end
        finish_test();
    end
endmodule
